// File: mat_pkg.sv
package mat_pkg;

	// Byte offsets on the register bus
	localparam logic [7:0] OFF_INSTR  = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_WREG   = 8'h08;
	localparam logic [7:0] OFF_PC     = 8'h0C;
	localparam logic [7:0] OFF_MADDR  = 8'h10;
	localparam logic [7:0] OFF_MDATA  = 8'h14;
	localparam logic [7:0] OFF_TBL    = 8'h18;
	localparam logic [7:0] OFF_CYC    = 8'h1C;

	// Status word layout
	localparam int STAT_FLAGS_LSB = 0;
	localparam int STAT_BUSY_BIT  = 8;

	// Timing
	localparam logic [1:0] SYS_PER_ICYC_M1 = 2'h3;
	localparam logic [1:0] ICYC_ONE        = 2'h1;
	localparam logic [1:0] ICYC_TWO        = 2'h2;

	// Data memory byte that aliases the low program counter byte
	localparam logic [7:0] PC_LOW_ADDR = 8'h06;

	// Reset values
	localparam logic [7:0] WREG_RST  = 8'h00;
	localparam logic [5:0] FLAGS_RST = 6'h00;
	localparam logic [7:0] TBL_RST   = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	typedef enum logic [5:0] {
		OP_NOP  = 6'h00, OP_ADD  = 6'h01, OP_ADC  = 6'h02, OP_SUB  = 6'h03,
		OP_SBC  = 6'h04, OP_AND  = 6'h05, OP_OR   = 6'h06, OP_XOR  = 6'h07,
		OP_COMPL = 6'h08, OP_INC = 6'h09, OP_DEC = 6'h0A, OP_RR = 6'h0B,
		OP_RL = 6'h0C, OP_RR_CARRY = 6'h0D, OP_RL_CARRY = 6'h0E, OP_BCD_ADJ = 6'h0F,
		OP_SETB = 6'h10, OP_CLRB = 6'h11, OP_MOVA = 6'h12, OP_MOVM = 6'h13,
		OP_SZ   = 6'h14, OP_SNZ  = 6'h15, OP_SZB  = 6'h16, OP_SNZB = 6'h17,
		OP_SIZ  = 6'h18, OP_SDZ  = 6'h19, OP_JMP  = 6'h1A, OP_CALL = 6'h1B,
		OP_RET  = 6'h1C, OP_INT_RET = 6'h1D, OP_TABRD = 6'h1E
	} mat_op_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} mat_state_t;

	// Instruction word; operand byte (address m or immediate) is target[7:0]
	typedef struct packed {
		logic [3:0]  rsv_hi;
		logic [11:0] target;
		logic [4:0]  rsv_lo;
		logic [2:0]  bit_sel;
		logic        imm_sel;
		logic        to_mem;
		mat_op_t     op;
	} mat_instr_t;

	typedef struct packed {
		logic compound_zero;
		logic aux_signed;
		logic signed_range;
		logic nibble_carry;
		logic c;
		logic z;
	} mat_flags_t;

endpackage

// File: mat_alu_core.sv
// Function
// - One instruction cycle is exactly four system clock cycles.
// - Most instructions take one cycle; branch, call, return, table read take two.
// - Writing the low program counter byte jumps there and adds one cycle.
// - A conditional skip takes two cycles when it skips, else one cycle.
// - A taken skip discards the next instruction and continues after it.
// - Call saves return address; return resumes after the call; jump saves nothing.
// - Bit set/clear change only bit 0..7, others kept by read-modify-write.
// - Add uses working register plus operand, optional carry; updates five flags.
// - Subtract operand from working register, optional borrow; adds compound zero flag.
// - Carry flag shows add result over 255, or no borrow on subtract (result at or above 0).
// - Memory-destination forms write the data memory byte, not the working register.
// - Decimal adjust corrects working register into memory, changing only carry.
// - AND, OR, XOR and complement update only zero flag, set on zero.
// - Complement inverts the memory byte into memory or working register.
// - Increment/decrement by one into memory or working register; zero flag only.
// - Plain rotates change no flags; rotates through carry pass bit via carry.
// - Basic memory forms reach only data memory sector 0.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module mat_alu_core
	import mat_pkg::*;
#(
	parameter int PC_W        = 12,
	parameter int STACK_DEPTH = 16,
	parameter int MEM_BYTES   = 512
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             busy
);

	localparam int MA_W = $clog2(MEM_BYTES);
	localparam int SP_W = $clog2(STACK_DEPTH);

	mat_state_t      state_reg;
	mat_instr_t      ir_reg;
	logic [1:0]      phase_reg;
	logic [1:0]      icnt_reg;
	logic [1:0]      total_reg;
	logic [7:0]      wreg_reg;
	mat_flags_t      flags_reg;
	logic [PC_W-1:0] pc_reg;
	logic [SP_W-1:0] sp_reg;
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	logic [7:0]      dmem [MEM_BYTES];
	logic [MA_W-1:0] maddr_reg;
	logic [7:0]      tbl_reg;

	logic            aw_hold_reg;
	logic            w_hold_reg;
	logic [7:0]      awaddr_reg;
	logic [31:0]     wdata_reg;
	logic [3:0]      wstrb_reg;
	logic [31:0]     wmerged;
	logic            wr_go;
	logic            wr_ok;
	logic            wr_map;
	logic            wr_guard;

	logic            commit;
	logic [MA_W-1:0] ex_addr;
	logic            pc_low_hit;
	logic [7:0]      mval;
	logic [7:0]      operand;
	logic [7:0]      bb;
	logic            cin;
	logic            is_sub;
	logic [8:0]      sum9;
	logic [4:0]      nib5;
	logic [8:0]      bcd_lo;
	logic [8:0]      bcd_hi;
	logic            bcd_hadj;
	logic [7:0]      res;
	logic [7:0]      mask;
	logic            wr_mem;
	logic            wr_acc;
	logic            skip;
	logic            jump;
	logic            push;
	logic            pop;
	logic            pc_low_dest;
	logic [1:0]      base;
	logic [1:0]      n_cyc;
	mat_flags_t      fl_n;
	logic [PC_W-1:0] pc_next;

	assign busy = (state_reg == ST_RUN);
	assign commit = busy && (phase_reg == 2'h0) && (icnt_reg == 2'h0);

	// Upper address bits pinned so only sector 0 is reachable
	assign ex_addr = {{(MA_W-8){1'b0}}, ir_reg.target[7:0]};
	assign pc_low_hit = (ir_reg.target[7:0] == PC_LOW_ADDR);
	assign mval    = pc_low_hit ? pc_reg[7:0] : dmem[ex_addr];
	assign operand = ir_reg.imm_sel ? ir_reg.target[7:0] : mval;
	assign mask    = 8'h01 << ir_reg.bit_sel;

	// One adder for both: subtract is add of inverse with carry-in
	assign is_sub = (ir_reg.op == OP_SUB) || (ir_reg.op == OP_SBC);
	assign bb     = is_sub ? ~operand : operand;
	assign cin    = (ir_reg.op == OP_SUB) ? 1'b1 :
	                ((ir_reg.op == OP_ADC) || (ir_reg.op == OP_SBC)) ? flags_reg.c : 1'b0;
	assign sum9   = {1'b0, wreg_reg} + {1'b0, bb} + {8'h00, cin};
	assign nib5   = {1'b0, wreg_reg[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};

	assign bcd_lo   = {1'b0, wreg_reg} +
	                  (((wreg_reg[3:0] > 4'h9) || flags_reg.nibble_carry) ? 9'h006 : 9'h000);
	assign bcd_hadj = (bcd_lo[7:4] > 4'h9) || flags_reg.c || bcd_lo[8];
	assign bcd_hi   = bcd_lo + (bcd_hadj ? 9'h060 : 9'h000);

	always_comb begin
		res   = mval;
		fl_n  = flags_reg;
		skip  = 1'b0;
		jump  = 1'b0;
		push  = 1'b0;
		pop   = 1'b0;
		base  = ICYC_ONE;
		wr_mem = 1'b0;
		wr_acc = 1'b0;
		case (ir_reg.op)
			OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
				res     = sum9[7:0];
				fl_n.z  = (sum9[7:0] == 8'h00);
				fl_n.c  = sum9[8];
				fl_n.nibble_carry = nib5[4];
				fl_n.signed_range = (wreg_reg[7] == bb[7]) && (sum9[7] != wreg_reg[7]);
				fl_n.aux_signed = fl_n.signed_range ^ sum9[7];
				if (is_sub) begin
					fl_n.compound_zero = (ir_reg.op == OP_SBC) ? (fl_n.z && flags_reg.z) : fl_n.z;
				end
				wr_mem = ir_reg.to_mem;
				wr_acc = !ir_reg.to_mem;
			end
			OP_AND, OP_OR, OP_XOR, OP_COMPL: begin
				case (ir_reg.op)
					OP_AND:  res = wreg_reg & operand;
					OP_OR:   res = wreg_reg | operand;
					OP_XOR:  res = wreg_reg ^ operand;
					default: res = ~mval;
				endcase
				fl_n.z = (res == 8'h00);
				wr_mem = ir_reg.to_mem;
				wr_acc = !ir_reg.to_mem;
			end
			OP_INC, OP_DEC: begin
				res    = (ir_reg.op == OP_INC) ? mval + 8'h01 : mval - 8'h01;
				fl_n.z = (res == 8'h00);
				wr_mem = ir_reg.to_mem;
				wr_acc = !ir_reg.to_mem;
			end
			OP_RR, OP_RL, OP_RR_CARRY, OP_RL_CARRY: begin
				case (ir_reg.op)
					OP_RR:       res = {mval[0], mval[7:1]};
					OP_RL:       res = {mval[6:0], mval[7]};
					OP_RR_CARRY: res = {flags_reg.c, mval[7:1]};
					default:     res = {mval[6:0], flags_reg.c};
				endcase
				if (ir_reg.op == OP_RR_CARRY) begin
					fl_n.c = mval[0];
				end else if (ir_reg.op == OP_RL_CARRY) begin
					fl_n.c = mval[7];
				end
				wr_mem = ir_reg.to_mem;
				wr_acc = !ir_reg.to_mem;
			end
			OP_BCD_ADJ: begin
				res    = bcd_hi[7:0];
				fl_n.c = bcd_hadj;
				wr_mem = 1'b1;
			end
			OP_SETB, OP_CLRB: begin
				res    = (ir_reg.op == OP_SETB) ? (mval | mask) : (mval & ~mask);
				wr_mem = 1'b1;
			end
			OP_MOVA: begin
				res    = operand;
				wr_acc = 1'b1;
			end
			OP_MOVM: begin
				res    = wreg_reg;
				wr_mem = 1'b1;
			end
			OP_SZ:   skip = (mval == 8'h00);
			OP_SNZ:  skip = (mval != 8'h00);
			OP_SZB:  skip = !mval[ir_reg.bit_sel];
			OP_SNZB: skip = mval[ir_reg.bit_sel];
			OP_SIZ, OP_SDZ: begin
				res    = (ir_reg.op == OP_SIZ) ? mval + 8'h01 : mval - 8'h01;
				skip   = (res == 8'h00);
				wr_mem = ir_reg.to_mem;
				wr_acc = !ir_reg.to_mem;
			end
			OP_JMP: begin
				jump = 1'b1;
				base = ICYC_TWO;
			end
			OP_CALL: begin
				push = 1'b1;
				base = ICYC_TWO;
			end
			OP_RET, OP_INT_RET: begin
				pop  = 1'b1;
				base = ICYC_TWO;
			end
			OP_TABRD: begin
				res    = tbl_reg;
				wr_mem = 1'b1;
				base   = ICYC_TWO;
			end
			default: begin
			end
		endcase
	end

	assign pc_low_dest = wr_mem && pc_low_hit;
	assign n_cyc = base + {1'b0, pc_low_dest} + {1'b0, skip};

	always_comb begin
		if (jump || push) begin
			pc_next = ir_reg.target[PC_W-1:0];
		end else if (pop) begin
			pc_next = stack_mem[sp_reg - SP_W'(1)];
		end else if (pc_low_dest) begin
			pc_next = {pc_reg[PC_W-1:8], res};
		end else begin
			pc_next = pc_reg + PC_W'(1) + PC_W'(skip);
		end
	end

	// Sequencer: instruction-cycle pacing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			phase_reg <= 2'h0;
			icnt_reg  <= 2'h0;
			total_reg <= ICYC_ONE;
		end else if (!busy) begin
			if (wr_ok && (awaddr_reg == OFF_INSTR)) begin
				state_reg <= ST_RUN;
				phase_reg <= 2'h0;
				icnt_reg  <= 2'h0;
			end
		end else begin
			phase_reg <= phase_reg + 2'h1;
			if (commit) begin
				total_reg <= n_cyc;
			end
			if (phase_reg == SYS_PER_ICYC_M1) begin
				if (icnt_reg + 2'h1 == (commit ? n_cyc : total_reg)) begin
					state_reg <= ST_IDLE;
				end else begin
					icnt_reg <= icnt_reg + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ir_reg <= '0;
		end else if (!busy && wr_ok && (awaddr_reg == OFF_INSTR)) begin
			ir_reg <= mat_instr_t'(wmerged);
		end
	end

	// Architectural state: software may touch it only while idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wreg_reg  <= WREG_RST;
			flags_reg <= mat_flags_t'(FLAGS_RST);
			pc_reg    <= '0;
			sp_reg    <= '0;
		end else if (commit) begin
			flags_reg <= fl_n;
			pc_reg    <= pc_next;
			if (wr_acc) begin
				wreg_reg <= res;
			end
			if (push) begin
				sp_reg <= sp_reg + SP_W'(1);
			end else if (pop) begin
				sp_reg <= sp_reg - SP_W'(1);
			end
		end else if (wr_ok) begin
			if (awaddr_reg == OFF_WREG) begin
				wreg_reg <= wmerged[7:0];
			end
			if (awaddr_reg == OFF_STATUS) begin
				flags_reg <= mat_flags_t'(wmerged[STAT_FLAGS_LSB +: 6]);
			end
			if (awaddr_reg == OFF_PC) begin
				pc_reg <= wmerged[PC_W-1:0];
			end
		end
	end

	// Stack and data memory hold no reset; contents are undefined at start
	always_ff @(posedge aclk) begin
		if (commit && push) begin
			stack_mem[sp_reg] <= pc_reg + PC_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (commit && wr_mem && !pc_low_hit) begin
			dmem[ex_addr] <= res;
		end else if (wr_ok && (awaddr_reg == OFF_MDATA)) begin
			dmem[maddr_reg] <= wmerged[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			maddr_reg <= '0;
			tbl_reg   <= TBL_RST;
		end else if (wr_ok) begin
			if (awaddr_reg == OFF_MADDR) begin
				maddr_reg <= wmerged[MA_W-1:0];
			end
			if (awaddr_reg == OFF_TBL) begin
				tbl_reg <= wmerged[7:0];
			end
		end
	end

	// Bus write side: address and data taken in either order
	assign s_axi_awready = !aw_hold_reg;
	assign s_axi_wready  = !w_hold_reg;
	assign wr_go   = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wr_map  = (awaddr_reg[7:5] == 3'h0) && (awaddr_reg[1:0] == 2'h0);
	// Writes other than MADDR and TBL refused while running so a launch cannot race the datapath
	assign wr_guard = busy && (awaddr_reg != OFF_MADDR) && (awaddr_reg != OFF_TBL);
	assign wr_ok   = wr_go && wr_map && !wr_guard && (awaddr_reg != OFF_CYC);

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmerged[8*i +: 8] = wstrb_reg[i] ? wdata_reg[8*i +: 8] : ir_reg[8*i +: 8];
		end
		if (awaddr_reg != OFF_INSTR) begin
			wmerged[7:0] = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg  <= 1'b0;
			w_hold_reg   <= 1'b0;
			awaddr_reg   <= 8'h00;
			wdata_reg    <= 32'h0000_0000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= !wr_map ? RESP_DECERR :
				                (wr_guard || awaddr_reg == OFF_CYC) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Bus read side
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
			case (s_axi_araddr)
				OFF_INSTR:  s_axi_rdata <= ir_reg;
				OFF_STATUS: s_axi_rdata <= {23'h0, busy, 2'h0, flags_reg};
				OFF_WREG:   s_axi_rdata <= {24'h0, wreg_reg};
				OFF_PC:     s_axi_rdata <= {{(32-PC_W){1'b0}}, pc_reg};
				OFF_MADDR:  s_axi_rdata <= {{(32-MA_W){1'b0}}, maddr_reg};
				OFF_MDATA:  s_axi_rdata <= {24'h0, dmem[maddr_reg]};
				OFF_TBL:    s_axi_rdata <= {24'h0, tbl_reg};
				OFF_CYC:    s_axi_rdata <= {30'h0, total_reg};
				default:    s_axi_rresp <= RESP_DECERR;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_busy4;
		busy [*4];
	endsequence

	sequence s_busy8;
		s_busy4 ##1 s_busy4;
	endsequence

	property p_one_icyc;
		commit && (ir_reg.op == OP_ADD) && !pc_low_dest |-> s_busy4 ##1 !busy;
	endproperty
	a_one_icyc: assert property (p_one_icyc) else $error("add not one cycle");

	property p_jump_two;
		commit && (ir_reg.op == OP_JMP) |-> s_busy8 ##1 !busy;
	endproperty
	a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

	property p_pc_low_extra;
		commit && pc_low_dest && !skip && (base == ICYC_ONE) |-> s_busy8 ##1 !busy;
	endproperty
	a_pc_low_extra: assert property (p_pc_low_extra) else $error("low pc byte write timing");

	property p_skip_pc;
		commit && skip && !pc_low_dest |=> pc_reg == $past(pc_reg) + PC_W'(2);
	endproperty
	a_skip_pc: assert property (p_skip_pc) else $error("skip pc wrong");

	property p_call_ret;
		commit && push |=> stack_mem[sp_reg - SP_W'(1)] == $past(pc_reg) + PC_W'(1);
	endproperty
	a_call_ret: assert property (p_call_ret) else $error("return address wrong");

	property p_bit_keep;
		commit && (ir_reg.op == OP_SETB) && !pc_low_hit |=>
			dmem[$past(ex_addr)] == ($past(mval) | $past(mask));
	endproperty
	a_bit_keep: assert property (p_bit_keep) else $error("bit set disturbed");

	property p_add_carry;
		commit && (ir_reg.op == OP_ADD) |=>
			flags_reg.c == ({1'b0, $past(wreg_reg)} + {1'b0, $past(operand)} > 9'h0FF);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

	property p_logic_c;
		commit && (ir_reg.op inside {OP_AND, OP_OR, OP_XOR, OP_COMPL, OP_INC}) |=>
			$stable(flags_reg.c) && $stable(flags_reg.signed_range);
	endproperty
	a_logic_c: assert property (p_logic_c) else $error("logic op touched carry");

	property p_rot_flags;
		commit && (ir_reg.op inside {OP_RR, OP_RL}) |=> $stable(flags_reg);
	endproperty
	a_rot_flags: assert property (p_rot_flags) else $error("plain rotate touched flags");

endmodule // mat_alu_core

// File: mat_bus_master.sv
`timescale 1ns/10ps
module mat_bus_master (
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'hF;
	end

	// Each task opens with an edge so no signal is driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule // mat_bus_master

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top
	import mat_pkg::*;
;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, busy;
	logic [1:0]  bresp, rresp, rs;
	int          fail_count = 0;
	int          comparisons = 0;
	int          bcnt = 0;
	int          mpc = 0;
	integer      seed = 28689;
	int          q[$];
	mat_op_t     ops[17] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_COMPL,
		OP_INC, OP_DEC, OP_RR, OP_RL, OP_RR_CARRY, OP_RL_CARRY, OP_BCD_ADJ, OP_SETB, OP_CLRB};
	mat_op_t     sk[6] = '{OP_SZ, OP_SNZ, OP_SZB, OP_SNZB, OP_SIZ, OP_SDZ};

	mat_alu_core i_mat_alu_core (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .busy(busy));

	mat_bus_master i_mat_bus_master (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	initial forever #10 aclk = ~aclk;

	// Busy length measured independently of the design's cycle register
	always @(posedge aclk) if (busy === 1'b1) bcnt <= bcnt + 1;

	task automatic chk(input string nm, input int e, input logic [31:0] g);
		comparisons++;
		if (g !== 32'(e)) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, 32'(e), g);
		end
	endtask

	task automatic w(input logic [7:0] a, input int d);
		i_mat_bus_master.wr(a, 32'(d), rs);
	endtask

	task automatic r(input logic [7:0] a);
		i_mat_bus_master.rd(a, rv, rs);
	endtask

	task automatic sm(input int adr, input int v);
		w(OFF_MADDR, adr);
		w(OFF_MDATA, v & 255);
	endtask

	task automatic gm(input int adr);
		w(OFF_MADDR, adr);
		r(OFF_MDATA);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Reference datapath; flag bits z, c, nibble, signed range, aux, compound zero from bit 0
	function automatic void alu(input mat_op_t op, input int a, b, f, bs, output int y, nf);
		int s, ci, bb, sa;
		nf = f;
		y = a;
		case (op)
			OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
				bb = (op == OP_SUB || op == OP_SBC) ? (~b & 255) : b;
				ci = (op == OP_ADD) ? 0 : (op == OP_SUB) ? 1 : f[1];
				s = a + bb + ci;
				y = s & 255;
				nf[1] = s > 255;
				nf[2] = (a & 15) + (bb & 15) + ci > 15;
				// Signed sum in full range, so overflow is judged by value
				sa = ((a ^ 128) - 128) + ((bb ^ 128) - 128) + ci;
				nf[3] = sa > 127 || sa < -128;
				nf[0] = y == 0;
				nf[4] = nf[3] ^ y[7];
				if (op == OP_SUB) nf[5] = nf[0];
				if (op == OP_SBC) nf[5] = nf[0] & f[0];
			end
			OP_AND: y = a & b;
			OP_OR: y = a | b;
			OP_XOR: y = a ^ b;
			OP_COMPL: y = ~b & 255;
			OP_INC: y = (b + 1) & 255;
			OP_DEC: y = (b - 1) & 255;
			OP_RR: y = ((b >> 1) | (b << 7)) & 255;
			OP_RL: y = ((b << 1) | (b >> 7)) & 255;
			OP_RR_CARRY: begin
				y = (b >> 1) | ((f & 2) << 6);
				nf[1] = b[0];
			end
			OP_RL_CARRY: begin
				y = ((b << 1) & 255) | ((f >> 1) & 1);
				nf[1] = b[7];
			end
			OP_BCD_ADJ: begin
				s = a + (((a & 15) > 9 || f[2]) ? 6 : 0);
				ci = ((s >> 4) & 15) > 9 || f[1] || s > 255;
				y = (s + (ci ? 96 : 0)) & 255;
				nf[1] = ci;
			end
			OP_SETB: y = b | (1 << bs);
			OP_CLRB: y = b & ~(1 << bs) & 255;
			default: y = a;
		endcase
		if (op >= OP_AND && op <= OP_DEC) nf[0] = y == 0;
	endfunction

	task automatic ex(input mat_op_t op, input logic tm, input logic im, input int bs,
		input logic [11:0] tg, input int en);
		mat_instr_t iw;
		int n0;
		iw = '{4'h0, tg, 5'h00, 3'(bs), im, tm, op};
		n0 = bcnt;
		w(OFF_INSTR, 32'(iw));
		chk("instr resp", RESP_OKAY, 32'(rs));
		while (busy === 1'b1) @(posedge aclk);
		chk("busy cycles", 4 * en, 32'(bcnt - n0));
		r(OFF_CYC);
		chk("cycles", en, rv);
		r(OFF_PC);
		chk("pc", mpc, rv);
	endtask

	initial begin
		// Traffic needs roughly 5000 cycles; allow twice that before giving up
		repeat (10000) @(posedge aclk);
		fail_count++;
		final_report();
	end

	initial begin
		int a, b, f, bs, m, k, y, nf, s;
		logic tm, im, dm;
		mat_op_t op;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		r(OFF_WREG);
		chk("wreg reset", 0, rv);
		r(OFF_STATUS);
		chk("status reset", 0, rv);
		r(OFF_PC);
		chk("pc reset", 0, rv);
		r(8'h20);
		chk("unmapped read", RESP_DECERR, 32'(rs));
		w(8'h21, 0);
		chk("unmapped write", RESP_DECERR, 32'(rs));
		w(OFF_CYC, 5);
		chk("cyc write", RESP_SLVERR, 32'(rs));
		$display("reset and map test done");
		for (int i = 0; i < 68; i++) begin
			op = ops[i % 17];
			k = i / 17;
			a = $random(seed) & 255;
			b = $random(seed) & 255;
			f = $random(seed) & 63;
			bs = $random(seed) & 7;
			m = $random(seed) & 255;
			if (m == 6) m = 7;
			tm = k[0];
			im = (k == 2) && (op <= OP_XOR);
			sm(256 + m, ~b);
			sm(m, b);
			w(OFF_WREG, a);
			w(OFF_STATUS, f);
			alu(op, a, b, f, bs, y, nf);
			dm = tm || op == OP_BCD_ADJ || op == OP_SETB || op == OP_CLRB;
			mpc = (mpc + 1) & 4095;
			// Bit 8 of the target set, so a leak past sector 0 would hit upper memory
			ex(op, tm, im, bs, 12'(im ? b : 256 + m), 1);
			r(OFF_WREG);
			chk("wreg", dm ? a : y, rv);
			r(OFF_STATUS);
			chk("flags", nf, rv);
			gm(m);
			chk("mem", dm ? y : b, rv);
			gm(256 + m);
			chk("upper mem", ~b & 255, rv);
		end
		$display("datapath test done");
		for (int j = 0; j < 18; j++) begin
			op = sk[j % 6];
			b = (j < 6) ? 0 : (j < 12) ? 255 : 1;
			bs = $random(seed) & 7;
			m = 64 + j;
			sm(m, b);
			y = (op == OP_SIZ) ? (b + 1) & 255 : (op == OP_SDZ) ? (b - 1) & 255 : b;
			s = (op == OP_SNZ) ? y != 0 : (op == OP_SZB) ? !y[bs] : (op == OP_SNZB) ? y[bs] : y == 0;
			mpc = (mpc + 1 + s) & 4095;
			ex(op, 1'b1, 1'b0, bs, 12'(m), 1 + s);
			gm(m);
			chk("skip mem", y, rv);
		end
		$display("skip test done");
		mpc = 'hA5C;
		ex(OP_JMP, 1'b0, 1'b0, 0, 12'hA5C, 2);
		q.push_back(mpc + 1);
		mpc = 'h123;
		ex(OP_CALL, 1'b0, 1'b0, 0, 12'h123, 2);
		q.push_back(mpc + 1);
		mpc = 'h2F0;
		ex(OP_CALL, 1'b0, 1'b0, 0, 12'h2F0, 2);
		mpc = q.pop_back();
		ex(OP_RET, 1'b0, 1'b0, 0, 12'h000, 2);
		mpc = q.pop_back();
		ex(OP_INT_RET, 1'b0, 1'b0, 0, 12'h000, 2);
		w(OFF_WREG, 'h3C);
		mpc = (mpc & 'hF00) | 'h3C;
		ex(OP_MOVM, 1'b1, 1'b0, 0, 12'h006, 2);
		w(OFF_TBL, 'h5A);
		mpc++;
		ex(OP_TABRD, 1'b1, 1'b0, 0, 12'h050, 2);
		gm('h50);
		chk("table byte", 'h5A, rv);
		mpc++;
		ex(OP_MOVA, 1'b0, 1'b0, 0, 12'h050, 1);
		mpc++;
		ex(OP_NOP, 1'b0, 1'b0, 0, 12'h000, 1);
		r(OFF_WREG);
		chk("moved byte", 'h5A, rv);
		$display("branch test done");
		// A jump keeps busy for eight cycles, long enough to collide with it
		w(OFF_INSTR, {4'h0, 12'h0F0, 10'h000, OP_JMP});
		w(OFF_WREG, 'h77);
		chk("busy write", RESP_SLVERR, 32'(rs));
		while (busy === 1'b1) @(posedge aclk);
		r(OFF_WREG);
		chk("wreg kept", 'h5A, rv);
		r(OFF_PC);
		chk("jump pc", 'h0F0, rv);
		$display("refusal test done");
		final_report();
	end
endmodule // tb_top
